// >>> hw/usmc_top.sv
// Wire mode, clock select, shifter, counter and pin drive of the
// universal serial interface. Pins arrive unsynchronised; the
// timer match input is a one-cycle pulse on CLK.
`timescale 1ns/1ps
module usmc_top
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic TIMER_MATCH,
  input wire logic [2:0] PIN_I,
  output logic [2:0] PIN_O,
  output logic [2:0] PIN_OE,
  output logic [2:0] PIN_PU
);
  import usmc_pkg::*;

  usmc_state_t s_q;
  usmc_state_t s_d;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_data;
  logic wr_port;
  logic strobe;
  logic toggle;
  logic sck_rise;
  logic sck_fall;
  logic start_det;
  logic sr_clk;
  logic cnt_clk;
  logic hold;
  logic cnt_sel_now;
  usmc_cs_t cs_now;

  always_comb
  begin
    s_d = s_q;
    wr_ctrl = 1'b0;
    wr_stat = 1'b0;
    wr_data = 1'b0;
    wr_port = 1'b0;
    strobe = 1'b0;
    toggle = 1'b0;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    start_det = 1'b0;
    sr_clk = 1'b0;
    cnt_clk = 1'b0;
    hold = 1'b0;
    cs_now = s_q.cs;
    cnt_sel_now = s_q.cnt_sel;
    if (CE)
    begin
      wr_ctrl = WR && (ADDR == A_CTRL);
      wr_stat = WR && (ADDR == A_STAT);
      wr_data = WR && (ADDR == A_DATA);
      wr_port = WR && (ADDR == A_PORT);
      // Inputs are sampled in every wire mode
      s_d.sync1 = PIN_I;
      s_d.sync2 = s_q.sync1;
      s_d.prev = s_q.sync2;
      sck_rise = s_q.sync2[PIN_SCK] && !s_q.prev[PIN_SCK];
      sck_fall = !s_q.sync2[PIN_SCK] && s_q.prev[PIN_SCK];
      start_det = s_q.prev[PIN_DI] && !s_q.sync2[PIN_DI]
        && s_q.sync2[PIN_SCK];
      if (wr_ctrl)
      begin
        s_d.wm = usmc_wm_t'(WDATA[CTRL_WM_HI:CTRL_WM_LO]);
        s_d.cs = usmc_cs_t'(WDATA[CTRL_CS_HI:CTRL_CS_LO]);
        // Kept only as the external counter source select
        s_d.cnt_sel = WDATA[CTRL_STROBE];
        cs_now = s_d.cs;
        cnt_sel_now = s_d.cnt_sel;
      end
      // Write pulses; toggle leaves no stored bit, strobe is also kept as cnt_sel
      strobe = wr_ctrl && WDATA[CTRL_STROBE];
      toggle = wr_ctrl && WDATA[CTRL_TOGGLE];
      if (wr_port)
      begin
        s_d.port = WDATA[2:0];
        s_d.dir = WDATA[PORT_DIR_LO+2:PORT_DIR_LO];
      end
      if (toggle)
      begin
        s_d.port[PIN_SCK] = !s_q.port[PIN_SCK];
      end
      case (cs_now)
        CS_SOFT:
        begin
          sr_clk = strobe;
          cnt_clk = strobe;
        end
        CS_TIMER:
        begin
          sr_clk = TIMER_MATCH;
          cnt_clk = TIMER_MATCH;
        end
        CS_EXT_POS:
        begin
          sr_clk = sck_rise;
          cnt_clk = cnt_sel_now ? toggle : (sck_rise || sck_fall);
        end
        CS_EXT_NEG:
        begin
          sr_clk = sck_fall;
          cnt_clk = cnt_sel_now ? toggle : (sck_rise || sck_fall);
        end
        default:
        begin
          sr_clk = 1'b0;
          cnt_clk = 1'b0;
        end
      endcase
      // A data write in the same cycle as a clock wins; no shift
      if (wr_data)
      begin
        s_d.sr = WDATA;
      end
      else if (sr_clk)
      begin
        s_d.sr = {s_q.sr[6:0], s_q.sync2[PIN_DI]};
      end
      // Flags: clear first so a same-cycle start sets SIF; a status write blocks the overflow set
      if (wr_stat)
      begin
        s_d.cnt = WDATA[STAT_CNT_HI:0];
        if (WDATA[STAT_SIF])
        begin
          s_d.sif = 1'b0;
        end
        if (WDATA[STAT_OIF])
        begin
          s_d.oif = 1'b0;
        end
      end
      else if (cnt_clk)
      begin
        s_d.cnt = s_q.cnt + CNT_ONE;
      end
      if (cnt_clk && !wr_stat && s_q.cnt == CNT_MAX)
      begin
        s_d.oif = 1'b1;
      end
      // Start detector runs only in the two-wire modes
      if (s_q.wm[1] && start_det)
      begin
        s_d.sif = 1'b1;
      end
      if (!cs_now[1])
      begin
        s_d.latch = s_d.sr[7];
      end
      else if (cs_now == CS_EXT_POS ? sck_fall : sck_rise)
      begin
        // Changes on the edge opposite the sampling edge
        s_d.latch = s_d.sr[7];
      end
      hold = s_d.sif
        || (s_d.wm == WM_TWO_HOLD && s_d.oif);
      // Plain port behaviour for every pin unless a mode overrides
      s_d.po = s_d.port;
      s_d.poe = s_d.dir;
      s_d.ppu = ~s_d.dir & s_d.port;
      case (s_d.wm)
        WM_OFF:
        begin
          s_d.po = s_d.port;
        end
        WM_THREE:
        begin
          s_d.po[PIN_DO] = s_d.latch;
        end
        WM_TWO, WM_TWO_HOLD:
        begin
          s_d.po[PIN_DI] = 1'b0;
          s_d.poe[PIN_DI] = s_d.dir[PIN_DI]
            && (!s_d.latch || !s_d.port[PIN_DI]);
          s_d.po[PIN_SCK] = 1'b0;
          s_d.poe[PIN_SCK] = s_d.dir[PIN_SCK]
            && (!s_d.port[PIN_SCK] || hold);
          s_d.ppu[PIN_DI] = 1'b0;
          s_d.ppu[PIN_SCK] = 1'b0;
        end
        default:
        begin
          s_d.po = s_d.port;
        end
      endcase
      s_d.rdata = 8'h00;
      if (RD)
      begin
        case (ADDR)
          A_CTRL: s_d.rdata = {2'h0, s_q.wm, s_q.cs, 2'h0};
          A_STAT: s_d.rdata = {s_q.sif, s_q.oif, 2'h0, s_q.cnt};
          A_DATA: s_d.rdata = s_q.sr;
          A_PORT: s_d.rdata = {1'b0, s_q.dir, 1'b0, s_q.port};
          default: s_d.rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      s_q <= USMC_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign RDATA = s_q.rdata;
  assign PIN_O = s_q.po;
  assign PIN_OE = s_q.poe;
  assign PIN_PU = s_q.ppu;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  property p_off_plain;
    CE && s_d.wm == WM_OFF |=> PIN_OE == $past(s_d.dir)
      && PIN_O == $past(s_d.port);
  endproperty
  a_off_plain: assert property (p_off_plain)
    else $error("off mode pins not plain port");

  property p_three_do;
    CE && s_d.wm == WM_THREE |=> PIN_O[PIN_DO] == $past(s_d.latch);
  endproperty
  a_three_do: assert property (p_three_do)
    else $error("three-wire data out not from latch");

  property p_sda_low;
    CE && s_d.wm[1] && s_d.dir[PIN_DI] && !s_d.latch
      |=> PIN_OE[PIN_DI] && !PIN_O[PIN_DI];
  endproperty
  a_sda_low: assert property (p_sda_low)
    else $error("data line not pulled low");

  sequence s_start_seen;
    CE && s_q.wm[1] && start_det && s_q.dir[PIN_SCK];
  endsequence
  sequence s_line_held;
    s_q.sif ##1 (PIN_OE[PIN_SCK] && !PIN_O[PIN_SCK]);
  endsequence
  property p_start_hold;
    s_start_seen ##1 CE && !wr_stat && !wr_port && !wr_ctrl
      |-> s_line_held;
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("start condition did not hold clock");

  property p_no_pullup;
    CE && s_d.wm[1] |=> !PIN_PU[PIN_DI] && !PIN_PU[PIN_SCK];
  endproperty
  a_no_pullup: assert property (p_no_pullup)
    else $error("pull-up active in two-wire mode");

  property p_ovf_hold;
    CE && s_d.wm == WM_TWO_HOLD && s_d.oif && s_d.dir[PIN_SCK]
      |=> PIN_OE[PIN_SCK];
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("overflow did not hold clock");

  property p_wrap;
    CE && cnt_clk && !wr_stat && s_q.cnt == CNT_MAX
      |=> s_q.cnt == 4'h0 && s_q.oif;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("overflow flag not set on wrap");

  property p_strobe_shift;
    CE && cs_now == CS_SOFT && strobe && !wr_data
      |=> s_q.sr == {$past(s_q.sr[6:0]), $past(s_q.sync2[PIN_DI])};
  endproperty
  a_strobe_shift: assert property (p_strobe_shift)
    else $error("strobe did not shift one step");

  property p_no_clock;
    CE && cs_now == CS_SOFT && !strobe && !wr_data
      |=> s_q.sr == $past(s_q.sr);
  endproperty
  a_no_clock: assert property (p_no_clock)
    else $error("shifter moved with no clock");

  property p_read_zero;
    CE && RD && ADDR == A_CTRL |=> RDATA[1:0] == 2'b00;
  endproperty
  a_read_zero: assert property (p_read_zero)
    else $error("strobe bits read non-zero");

  property p_toggle;
    CE && toggle |=> s_q.port[PIN_SCK] != $past(s_q.port[PIN_SCK]);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle did not invert clock port");

  property p_toggle_count;
    CE && toggle && cs_now[1] && cnt_sel_now && !wr_stat
      |=> s_q.cnt == $past(s_q.cnt) + CNT_ONE;
  endproperty
  a_toggle_count: assert property (p_toggle_count)
    else $error("toggle did not clock counter");

  property p_latch_internal;
    CE && !cs_now[1] |=> s_q.latch == s_q.sr[7];
  endproperty
  a_latch_internal: assert property (p_latch_internal)
    else $error("latch not transparent");

  property p_ext_latch;
    CE && cs_now == CS_EXT_POS && !sck_fall
      |=> s_q.latch == $past(s_q.latch);
  endproperty
  a_ext_latch: assert property (p_ext_latch)
    else $error("external latch moved off the output edge");
endmodule

// >>> hw/usmc_pkg.sv
// Constants and types for the serial mode and clock select block.
// Assumes a plain register port with one-cycle read latency.
// Function
// - Mode zero disables outputs, hold, start detect
// - Inputs keep working in every wire mode
// - Three-wire: data-out replaces port output bit
// - Three-wire: data-in and clock pins stay normal
// - Two-wire: open-drain lines gated by direction
// - Data line low if shifter or port zero
// - Clock line low if port zero or hold
// - Start condition holds clock until flag cleared
// - Two-wire disables pull-ups on both lines
// - Mode three also holds clock on overflow
// - External clock: output on opposite edge
// - Strobe or timer source: latch transparent
// - Clock source table for strobe and timer
// - External edge choice and counter source
// - Strobe shifts once, increments counter
// - Strobe and toggle bits read zero
// - Toggle write inverts clock pin port value
// - Toggle write clocks counter in external mode
// - Serial output comes from shifter top bit
// - Overflow flag set on wrap to zero
package usmc_pkg;
  localparam logic [1:0] A_CTRL = 2'h0;
  localparam logic [1:0] A_STAT = 2'h1;
  localparam logic [1:0] A_DATA = 2'h2;
  localparam logic [1:0] A_PORT = 2'h3;
  localparam int CTRL_WM_HI = 5;
  localparam int CTRL_WM_LO = 4;
  localparam int CTRL_CS_HI = 3;
  localparam int CTRL_CS_LO = 2;
  localparam int CTRL_STROBE = 1;
  localparam int CTRL_TOGGLE = 0;
  localparam int STAT_SIF = 7;
  localparam int STAT_OIF = 6;
  localparam int STAT_CNT_HI = 3;
  localparam int PORT_DIR_LO = 4;
  localparam int PIN_DI = 0;
  localparam int PIN_DO = 1;
  localparam int PIN_SCK = 2;
  localparam logic [3:0] CNT_MAX = 4'hf;
  localparam logic [3:0] CNT_ONE = 4'h1;
  typedef enum logic [1:0] {
    WM_OFF = 2'b00,
    WM_THREE = 2'b01,
    WM_TWO = 2'b10,
    WM_TWO_HOLD = 2'b11
  } usmc_wm_t;
  typedef enum logic [1:0] {
    CS_SOFT = 2'b00,
    CS_TIMER = 2'b01,
    CS_EXT_POS = 2'b10,
    CS_EXT_NEG = 2'b11
  } usmc_cs_t;
  typedef struct packed {
    usmc_wm_t wm;
    usmc_cs_t cs;
    logic cnt_sel;
    logic [2:0] port;
    logic [2:0] dir;
    logic [7:0] sr;
    logic latch;
    logic [3:0] cnt;
    logic sif;
    logic oif;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] prev;
    logic [7:0] rdata;
    logic [2:0] po;
    logic [2:0] poe;
    logic [2:0] ppu;
  } usmc_state_t;
  localparam usmc_state_t USMC_RESET = '0;
endpackage

// >>> sim/usmc_peer.sv
// Serial peer on the data and clock lines of the pin port.
// Assumes open-drain lines; the block pulls low through PIN_OE.
`timescale 1ns/1ps
module usmc_peer
(
  input wire logic [2:0] pin_o,
  input wire logic [2:0] pin_oe,
  output logic [2:0] pin_i
);
  logic sda = 1'b1;
  logic scl = 1'b1;
  // Wired-AND: either party may pull a line low
  // Undriven data-out pin rests at its pull-up
  assign pin_i = {scl & ~(pin_oe[2] & ~pin_o[2]),
    pin_oe[1] ? pin_o[1] : 1'b1,
    sda & ~(pin_oe[0] & ~pin_o[0])};
  // Data changes mid-high so both clock edges see it stable
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      sda = b[i];
      #40 scl = 1'b0;
      #80 scl = 1'b1;
      #40;
    end
  endtask
  task automatic start_cond();
    #40 sda = 1'b0;
    #160 sda = 1'b1;
  endtask
endmodule

// >>> sim/usmc_top_tb.sv
// Self-checking bench for the serial mode and clock select block.
// Assumes the peer model sits on the data and clock pins.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module usmc_top_tb;
  import usmc_pkg::*;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic CE = 1'b1;
  logic [1:0] ADDR = 2'h0;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic TIMER_MATCH = 1'b0;
  logic [7:0] RDATA;
  logic [2:0] PIN_I;
  logic [2:0] PIN_O;
  logic [2:0] PIN_OE;
  logic [2:0] PIN_PU;
  int failures = 0;
  int n_tests = 0;
  logic [7:0] d;
  logic [7:0] r;
  always #5 CLK = ~CLK;
  usmc_top dut (.CLK(CLK), .RST(RST), .CE(CE), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .TIMER_MATCH(TIMER_MATCH), .PIN_I(PIN_I), .PIN_O(PIN_O),
    .PIN_OE(PIN_OE), .PIN_PU(PIN_PU));
  usmc_peer peer (.pin_o(PIN_O), .pin_oe(PIN_OE), .pin_i(PIN_I));
  function automatic logic [7:0] shl(input logic [7:0] v, input logic b);
    return {v[6:0], b};
  endfunction
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic chk_rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 r = RDATA;
    `CHK(r, e)
  endtask
  task automatic settle();
    repeat (2) @(posedge CLK);
    #1;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #200000;
    failures++;
    final_report();
  end
  initial
  begin
    void'($urandom(32'hf1b9));
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    for (int a = 0; a < 4; a++)
      chk_rd(a[1:0], 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      d = 8'($urandom) & 8'h3c;
      wr(A_CTRL, d | 8'hc3);
      chk_rd(A_CTRL, d);
    end
    $display("test control readback done");
    wr(A_CTRL, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      d = 8'($urandom) & 8'h77;
      wr(A_PORT, d);
      settle();
      `CHK(PIN_O, d[2:0])
      `CHK(PIN_OE, d[6:4])
      `CHK(PIN_PU, ~d[6:4] & d[2:0])
    end
    $display("test port mode done");
    wr(A_PORT, 8'h20);
    wr(A_CTRL, 8'h10);
    d = 8'($urandom);
    wr(A_DATA, d);
    // Earlier control writes may have clocked the counter
    wr(A_STAT, 8'hc0);
    peer.sda = ~d[0];
    wr(A_CTRL, 8'h10);
    settle();
    chk_rd(A_DATA, d);
    wr(A_CTRL, 8'h12);
    settle();
    `CHK(PIN_O[1], d[6])
    `CHK(PIN_OE[1], 1'b1)
    chk_rd(A_DATA, shl(d, ~d[0]));
    chk_rd(A_STAT, 8'h01);
    $display("test strobe done");
    wr(A_CTRL, 8'h04);
    for (int i = 0; i < 15; i++)
    begin
      @(posedge CLK);
      TIMER_MATCH <= 1'b1;
      @(posedge CLK);
      TIMER_MATCH <= 1'b0;
    end
    chk_rd(A_STAT, 8'h40);
    $display("test timer done");
    peer.sda = 1'b1;
    wr(A_PORT, 8'h55);
    wr(A_CTRL, 8'h30);
    settle();
    `CHK(PIN_I[2], 1'b0)
    `CHK(PIN_PU, 3'h0)
    // Pull the data line low while the clock is still held, so that
    // releasing the clock cannot look like a start condition
    wr(A_DATA, 8'h00);
    wr(A_STAT, 8'h40);
    settle();
    `CHK(PIN_I[2], 1'b1)
    `CHK(PIN_I[0], 1'b0)
    wr(A_DATA, 8'h80);
    settle();
    `CHK(PIN_I[0], 1'b1)
    peer.start_cond();
    settle();
    `CHK(PIN_I[2], 1'b0)
    chk_rd(A_STAT, 8'h80);
    wr(A_STAT, 8'h80);
    settle();
    `CHK(PIN_I[2], 1'b1)
    // Plain two-wire mode: overflow must not hold the clock
    wr(A_DATA, 8'hc0);
    wr(A_CTRL, 8'h20);
    wr(A_STAT, 8'h0f);
    wr(A_CTRL, 8'h22);
    settle();
    `CHK(PIN_I[2], 1'b1)
    chk_rd(A_STAT, 8'h40);
    wr(A_STAT, 8'h40);
    $display("test two-wire hold done");
    wr(A_PORT, 8'h00);
    wr(A_CTRL, 8'h0a);
    wr(A_CTRL, 8'h0b);
    settle();
    chk_rd(A_PORT, 8'h04);
    `CHK(PIN_OE[2], 1'b0)
    chk_rd(A_STAT, 8'h01);
    $display("test toggle done");
    for (int s = 2; s < 4; s++)
    begin
      d = 8'($urandom);
      wr(A_CTRL, 8'(s << 2));
      wr(A_STAT, 8'h40);
      peer.send_byte(d);
      settle();
      chk_rd(A_DATA, d);
      chk_rd(A_STAT, 8'h40);
    end
    $display("test external clock done");
    final_report();
  end
endmodule
